// *** src/trpc_map.svh ***
`ifndef TRPC_MAP_SVH
`define TRPC_MAP_SVH

// Register byte offsets on the sequencer's APB port
`define TRPC_CTRL_OFS       12'h000
`define TRPC_STATUS_OFS     12'h004
`define TRPC_HOLD_OFS       12'h008

// Control register fields
`define TRPC_CTRL_START_BIT 0
`define TRPC_CTRL_PWRDN_BIT 1
`define TRPC_CTRL_RECFG_BIT 2

// Status register fields
`define TRPC_STS_RUN_BIT    0
`define TRPC_STS_PLL_BIT    1
`define TRPC_STS_FREQ_BIT   2
`define TRPC_STS_BUSY_BIT   3
`define TRPC_STS_RECFG_BIT  4

// Reset values
`define TRPC_HOLD_RST       16'h0010
`define TRPC_PRBS_SEED      7'h7f

// Channel count, then timing counts in parallel clock cycles
`define TRPC_NCH            4
`define TRPC_MIN_RST_CYC    2
`define TRPC_PLL_LOCK_CYC   64
`define TRPC_CDR_LOCK_CYC   32
`define TRPC_OFFSET_CYC     100
`define TRPC_RECFG_CYC      8

`endif

// *** src/trpc_pkg.sv ***
package trpc_pkg;

    typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_DATA} trpc_tx_st_t;

    typedef enum logic [1:0] {RX_HUNT, RX_SYNC, RX_ALIGNED} trpc_rx_st_t;

    typedef enum logic [2:0] {
        HS_ALL_RST,
        HS_PLL_WAIT,
        HS_CDR_WAIT,
        HS_DIG_HOLD,
        HS_RUN
    } trpc_host_st_t;

endpackage : trpc_pkg

// *** src/trpc_if.sv ***
`timescale 1ns/100ps
`include "trpc_map.svh"

interface trpc_if #(
    parameter int NCH = `TRPC_NCH
);
    logic [NCH-1:0] tx_digital_rst;
    logic [NCH-1:0] rx_digital_rst;
    logic [NCH-1:0] rx_analog_rst;
    logic           pll_rst;
    logic           blk_pwrdn;
    logic           pll_locked;
    logic [NCH-1:0] rx_freq_locked;
    logic           recfg_busy;

    modport dev (
        input  tx_digital_rst,
        input  rx_digital_rst,
        input  rx_analog_rst,
        input  pll_rst,
        input  blk_pwrdn,
        output pll_locked,
        output rx_freq_locked,
        output recfg_busy
    );

    modport usr (
        output tx_digital_rst,
        output rx_digital_rst,
        output rx_analog_rst,
        output pll_rst,
        output blk_pwrdn,
        input  pll_locked,
        input  rx_freq_locked,
        input  recfg_busy
    );

endinterface : trpc_if

// *** src/trpc_lock.sv ***
`timescale 1ns/100ps

module trpc_lock #(
    parameter int CYC = 16
)(
    // Clock and clear
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Count enable and result
    input  wire logic en_in,
    output wire logic locked_out
);
    localparam int CW = $clog2(CYC + 1);

    logic [CW-1:0] cnt_q;
    logic          locked_q;

    assign locked_out = locked_q;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_q    <= '0;
            locked_q <= 1'b0;
        end
        else if (!en_in)
        begin
            cnt_q    <= '0;
            locked_q <= 1'b0;
        end
        else if (cnt_q == CW'(CYC - 1))
        begin
            locked_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

endmodule : trpc_lock

// *** src/trpc_dev.sv ***
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "trpc_map.svh"
// Function
// - Resets and power-down act asynchronously on assertion
// - Each channel has its own reset inputs
// - Transmit digital reset clears transmit coding logic
// - Receive digital reset clears receive logic, verifiers
// - Digital resets held at least two cycles
// - Analog reset clears CDR, held two cycles
// - Digital resets held until clocks stable
// - PLL reset clears the transceiver PLL
// - Reconfig controller drives PLL reset after reconfig
// - Power-down removes power from all channels, PLL
// - Power-down independent, common to whole block
// - PLL lock output high when locked
// - Frequency lock high in lock-to-data mode
// - Busy low first cycle, high during cancellation
module trpc_dev
    import trpc_pkg::*;
#(
    parameter int NCH          = `TRPC_NCH,
    parameter int PLL_LOCK_CYC = `TRPC_PLL_LOCK_CYC,
    parameter int CDR_LOCK_CYC = `TRPC_CDR_LOCK_CYC,
    parameter int OFFSET_CYC   = `TRPC_OFFSET_CYC
)(
    // Clock and reset
    input  wire logic           mclk_in,
    input  wire logic           arst_n_in,
    // Link to the sequencer
    trpc_if.dev                 lnk,
    // User-side status
    output wire logic [NCH-1:0] tx_active_out,
    output wire logic [NCH-1:0] rx_aligned_out,
    output wire logic [NCH-1:0] bist_ok_out,
    output wire logic           pwr_on_out
);
    localparam int OCW = $clog2(OFFSET_CYC + 1);

    logic           pll_rst_n;
    logic           pwr_rst_n;
    logic           pll_lock_w;
    wire  [NCH-1:0] freq_lock_w;
    logic           pwr_on_q;
    logic           busy_q;
    logic           started_q;
    logic [OCW-1:0] oc_cnt_q;

    // Power-down ignores the link's other reset inputs; only the master reset shares its net
    assign pwr_rst_n = arst_n_in & ~lnk.blk_pwrdn;
    assign pll_rst_n = pwr_rst_n & ~lnk.pll_rst;

    trpc_lock #(
        .CYC        (PLL_LOCK_CYC)
    ) u_pll_lock (
        .clk_in     (mclk_in),
        .rst_n_in   (pll_rst_n),
        .en_in      (1'b1),
        .locked_out (pll_lock_w)
    );

    assign lnk.pll_locked     = pll_lock_w;
    assign lnk.rx_freq_locked = freq_lock_w;
    assign lnk.recfg_busy     = busy_q;
    assign pwr_on_out         = pwr_on_q;

    always_ff @(posedge mclk_in or negedge pwr_rst_n)
    begin
        if (!pwr_rst_n)
        begin
            pwr_on_q <= 1'b0;
        end
        else
        begin
            pwr_on_q <= 1'b1;
        end
    end

    // Offset cancellation only after power-up, not after power-down
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            busy_q    <= 1'b0;
            started_q <= 1'b0;
            oc_cnt_q  <= '0;
        end
        else
        begin
            started_q <= 1'b1;
            if (!started_q)
            begin
                busy_q <= 1'b1;
            end
            else if (busy_q)
            begin
                if (oc_cnt_q == OCW'(OFFSET_CYC - 1))
                begin
                    busy_q <= 1'b0;
                end
                oc_cnt_q <= oc_cnt_q + OCW'(1);
            end
        end
    end

    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        logic        ana_rst_n;
        logic        tx_rst_n;
        logic        rx_rst_n;
        logic        lpbk_vld;
        logic        prbs_hit;
        logic        inc_hit;
        logic [6:0]  prbs_nxt;
        trpc_tx_st_t tx_st_q;
        trpc_tx_st_t tx_st_d;
        trpc_rx_st_t rx_st_q;
        trpc_rx_st_t rx_st_d;
        logic [6:0]  tx_prbs_q;
        logic [7:0]  tx_inc_q;
        logic        tx_act_q;
        logic [6:0]  rx_prbs_q;
        logic [7:0]  rx_inc_q;
        logic        bist_err_q;
        logic        rx_align_q;
        logic        bist_ok_q;

        // Separate reset per channel and per direction
        assign ana_rst_n = pwr_rst_n & ~lnk.rx_analog_rst[i];
        assign tx_rst_n  = pwr_rst_n & ~lnk.tx_digital_rst[i];
        assign rx_rst_n  = pwr_rst_n & ~lnk.rx_digital_rst[i];

        // CDR leaves lock-to-reference once the PLL is stable
        trpc_lock #(
            .CYC        (CDR_LOCK_CYC)
        ) u_cdr_lock (
            .clk_in     (mclk_in),
            .rst_n_in   (ana_rst_n),
            .en_in      (pll_lock_w),
            .locked_out (freq_lock_w[i])
        );

        assign prbs_nxt = {tx_prbs_q[5:0], tx_prbs_q[6] ^ tx_prbs_q[5]};
        // Internal loopback: receiver sees its own transmitter
        assign lpbk_vld = freq_lock_w[i] & tx_act_q;
        assign prbs_hit = tx_prbs_q == {rx_prbs_q[5:0], rx_prbs_q[6] ^ rx_prbs_q[5]};
        assign inc_hit  = tx_inc_q == rx_inc_q + 8'h01;

        always_comb
        begin
            tx_st_d = tx_st_q;
            case (tx_st_q)
                TX_IDLE: tx_st_d = TX_SYNC;
                TX_SYNC: if (pll_lock_w) tx_st_d = TX_DATA;
                TX_DATA: if (!pll_lock_w) tx_st_d = TX_SYNC;
                default: tx_st_d = TX_IDLE;
            endcase
        end

        always_ff @(posedge mclk_in or negedge tx_rst_n)
        begin
            if (!tx_rst_n)
            begin
                tx_st_q   <= TX_IDLE;
                tx_prbs_q <= `TRPC_PRBS_SEED;
                tx_inc_q  <= 8'h00;
                tx_act_q  <= 1'b0;
            end
            else
            begin
                tx_st_q  <= tx_st_d;
                tx_act_q <= tx_st_d == TX_DATA;
                if (tx_st_q == TX_DATA)
                begin
                    tx_prbs_q <= prbs_nxt;
                    tx_inc_q  <= tx_inc_q + 8'h01;
                end
            end
        end

        always_comb
        begin
            rx_st_d = rx_st_q;
            case (rx_st_q)
                RX_HUNT:    if (lpbk_vld) rx_st_d = RX_SYNC;
                RX_SYNC:    rx_st_d = lpbk_vld ? RX_ALIGNED : RX_HUNT;
                RX_ALIGNED: if (!lpbk_vld) rx_st_d = RX_HUNT;
                default:    rx_st_d = RX_HUNT;
            endcase
        end

        // Verifier errors are sticky until the next receive reset
        always_ff @(posedge mclk_in or negedge rx_rst_n)
        begin
            if (!rx_rst_n)
            begin
                rx_st_q    <= RX_HUNT;
                rx_prbs_q  <= 7'h00;
                rx_inc_q   <= 8'h00;
                bist_err_q <= 1'b0;
                rx_align_q <= 1'b0;
                bist_ok_q  <= 1'b0;
            end
            else
            begin
                rx_st_q    <= rx_st_d;
                rx_prbs_q  <= tx_prbs_q;
                rx_inc_q   <= tx_inc_q;
                rx_align_q <= rx_st_d == RX_ALIGNED;
                if (rx_st_q == RX_ALIGNED && lpbk_vld && !(prbs_hit && inc_hit))
                begin
                    bist_err_q <= 1'b1;
                end
                bist_ok_q  <= rx_st_d == RX_ALIGNED && !bist_err_q;
            end
        end

        assign tx_active_out[i]  = tx_act_q;
        assign rx_aligned_out[i] = rx_align_q;
        assign bist_ok_out[i]    = bist_ok_q;
    end

endmodule : trpc_dev

// *** src/trpc_host.sv ***
`timescale 1ns/100ps
`include "trpc_map.svh"

module trpc_host
    import trpc_pkg::*;
#(
    parameter int NCH       = `TRPC_NCH,
    parameter int MIN_CYC   = `TRPC_MIN_RST_CYC,
    parameter int RECFG_CYC = `TRPC_RECFG_CYC
)(
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        arst_n_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Link to the transceiver block
    trpc_if.usr              lnk,
    // User-side status
    output logic             seq_done_out
);
    localparam int RCW = $clog2(RECFG_CYC + 1);

    trpc_host_st_t st_q;
    trpc_host_st_t st_d;
    logic [15:0]   cnt_q;
    logic [15:0]   cnt_d;
    logic [15:0]   hold_q;
    logic [15:0]   hold_lim;
    logic          pwrdn_q;
    logic          recfg_act_q;
    logic          recfg_act_d;
    logic [RCW-1:0] recfg_cnt_q;
    logic [NCH-1:0] tx_rst_q;
    logic [NCH-1:0] rx_rst_q;
    logic [NCH-1:0] ana_rst_q;
    logic          pll_rst_q;

    wire setup    = psel_in & ~penable_in;
    wire wr       = psel_in & penable_in & pready_out & pwrite_in;
    wire sel_ctrl = paddr_in == `TRPC_CTRL_OFS;
    wire sel_sts  = paddr_in == `TRPC_STATUS_OFS;
    wire sel_hold = paddr_in == `TRPC_HOLD_OFS;
    wire mapped   = sel_ctrl | sel_sts | sel_hold;
    wire wr_ctrl  = wr & sel_ctrl;
    wire start    = wr_ctrl & pwdata_in[`TRPC_CTRL_START_BIT];
    wire recfg_go = wr_ctrl & pwdata_in[`TRPC_CTRL_RECFG_BIT] & ~recfg_act_q;
    wire all_frq  = &lnk.rx_freq_locked;

    wire [31:0] ctrl_rd = 32'(pwrdn_q) << `TRPC_CTRL_PWRDN_BIT;
    wire [31:0] sts_rd  = (32'(st_q == HS_RUN) << `TRPC_STS_RUN_BIT)
                        | (32'(lnk.pll_locked) << `TRPC_STS_PLL_BIT)
                        | (32'(all_frq) << `TRPC_STS_FREQ_BIT)
                        | (32'(lnk.recfg_busy) << `TRPC_STS_BUSY_BIT)
                        | (32'(recfg_act_q) << `TRPC_STS_RECFG_BIT);
    wire [31:0] rd_data = sel_ctrl ? ctrl_rd
                        : sel_sts  ? sts_rd
                        : sel_hold ? {16'h0000, hold_q}
                        : 32'h0000_0000;

    // A short hold would undercut the minimum pulse width
    assign hold_lim = (hold_q < 16'(MIN_CYC)) ? 16'(MIN_CYC) : hold_q;

    // Reconfiguration controller owns the PLL reset after a retune
    assign recfg_act_d = recfg_go | (recfg_act_q & (recfg_cnt_q != RCW'(RECFG_CYC - 1)));

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            HS_ALL_RST:  if (cnt_q >= 16'(MIN_CYC - 1)) st_d = HS_PLL_WAIT;
            HS_PLL_WAIT: if (!recfg_act_q && lnk.pll_locked && !lnk.recfg_busy)
                             st_d = HS_CDR_WAIT;
            HS_CDR_WAIT: if (!lnk.pll_locked) st_d = HS_PLL_WAIT;
                         else if (all_frq) st_d = HS_DIG_HOLD;
            HS_DIG_HOLD: if (!(lnk.pll_locked && all_frq)) st_d = HS_PLL_WAIT;
                         else if (cnt_q >= hold_lim - 16'h0001) st_d = HS_RUN;
            HS_RUN:      if (!lnk.pll_locked) st_d = HS_ALL_RST;
            default:     st_d = HS_ALL_RST;
        endcase
        if (start || pwrdn_q)
            st_d = HS_ALL_RST;
        else if (recfg_go)
            st_d = HS_PLL_WAIT;
        cnt_d = (st_d != st_q) ? 16'h0000 : (&cnt_q ? cnt_q : cnt_q + 16'h0001);
    end

    assign lnk.tx_digital_rst = tx_rst_q;
    assign lnk.rx_digital_rst = rx_rst_q;
    assign lnk.rx_analog_rst  = ana_rst_q;
    assign lnk.pll_rst        = pll_rst_q;
    assign lnk.blk_pwrdn      = pwrdn_q;

    // All releases come from flops on the parallel clock
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st_q         <= HS_ALL_RST;
            cnt_q        <= 16'h0000;
            tx_rst_q     <= '1;
            rx_rst_q     <= '1;
            ana_rst_q    <= '1;
            pll_rst_q    <= 1'b1;
            seq_done_out <= 1'b0;
        end
        else
        begin
            st_q         <= st_d;
            cnt_q        <= cnt_d;
            tx_rst_q     <= {NCH{st_d != HS_RUN}};
            rx_rst_q     <= {NCH{st_d != HS_RUN}};
            ana_rst_q    <= {NCH{st_d == HS_ALL_RST || st_d == HS_PLL_WAIT}};
            pll_rst_q    <= (st_d == HS_ALL_RST) | recfg_act_d;
            seq_done_out <= st_d == HS_RUN;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            recfg_act_q <= 1'b0;
            recfg_cnt_q <= '0;
        end
        else
        begin
            recfg_act_q <= recfg_act_d;
            recfg_cnt_q <= recfg_go ? '0 : recfg_cnt_q + RCW'(recfg_act_q);
        end
    end

    // Zero-wait APB: answer prepared during the setup cycle
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            pwrdn_q     <= 1'b0;
            hold_q      <= `TRPC_HOLD_RST;
        end
        else
        begin
            pready_out  <= setup;
            pslverr_out <= setup & ~mapped;
            if (setup)
                prdata_out <= pwrite_in ? 32'h0000_0000 : rd_data;
            if (wr_ctrl)
                pwrdn_q <= pwdata_in[`TRPC_CTRL_PWRDN_BIT];
            if (wr & sel_hold)
                hold_q <= pwdata_in[15:0];
        end
    end

endmodule : trpc_host

// *** verification/trpc_props.sv ***
`timescale 1ns/100ps

module trpc_props #(
    parameter int NCH          = 4,
    parameter int PLL_LOCK_CYC = 8,
    parameter int CDR_LOCK_CYC = 4
)(
    // Clock and reset
    input wire logic           mclk_in,
    input wire logic           arst_n_in,
    // Link signals
    input wire logic [NCH-1:0] tx_digital_rst,
    input wire logic [NCH-1:0] rx_digital_rst,
    input wire logic [NCH-1:0] rx_analog_rst,
    input wire logic           pll_rst,
    input wire logic           blk_pwrdn,
    input wire logic           pll_locked,
    input wire logic [NCH-1:0] rx_freq_locked,
    input wire logic           recfg_busy
);
    // Slack over the lock count for the state hop in the sequencer
    localparam int LK_W = PLL_LOCK_CYC + 4;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!arst_n_in);

    property p_pll_clr;
        (pll_rst || blk_pwrdn) |-> !pll_locked;
    endproperty
    a_pll_clr: assert property (p_pll_clr) else $error("pll lock under reset");

    property p_freq_clr;
        ((rx_analog_rst | {NCH{blk_pwrdn}}) & rx_freq_locked) == '0;
    endproperty
    a_freq_clr: assert property (p_freq_clr) else $error("freq lock under reset");

    property p_lock_early;
        $rose(pll_locked) |-> !$past(pll_rst, PLL_LOCK_CYC - 1);
    endproperty
    a_lock_early: assert property (p_lock_early) else $error("pll lock too early");

    property p_lock_late;
        $fell(pll_rst) |-> ##[1:LK_W] (pll_locked || pll_rst || blk_pwrdn);
    endproperty
    a_lock_late: assert property (p_lock_late) else $error("pll lock too late");

    property p_freq_early;
        $rose(rx_freq_locked[0]) |-> !$past(rx_analog_rst[0], CDR_LOCK_CYC - 1)
            && $past(pll_locked, CDR_LOCK_CYC - 1);
    endproperty
    a_freq_early: assert property (p_freq_early) else $error("freq lock too early");

    // Offset cancellation length matches the bench's shortened count
    property p_busy_start;
        $rose(arst_n_in) |-> !recfg_busy ##1 recfg_busy [*5] ##1 !recfg_busy;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy profile wrong");

    property p_dig_min;
        $rose(tx_digital_rst[0]) || $rose(rx_digital_rst[0])
            |=> tx_digital_rst[0] && rx_digital_rst[0];
    endproperty
    a_dig_min: assert property (p_dig_min) else $error("digital pulse short");

    property p_ana_min;
        $rose(rx_analog_rst[0]) |-> rx_analog_rst[0] [*2];
    endproperty
    a_ana_min: assert property (p_ana_min) else $error("analog pulse short");

    property p_pll_min;
        $rose(pll_rst) |-> pll_rst [*2];
    endproperty
    a_pll_min: assert property (p_pll_min) else $error("pll reset pulse short");

    property p_dig_rel;
        $fell(rx_digital_rst[0]) |-> pll_locked && rx_freq_locked[0] && !rx_analog_rst[0];
    endproperty
    a_dig_rel: assert property (p_dig_rel) else $error("digital released early");

    property p_ana_rel;
        $fell(rx_analog_rst[0]) |-> rx_digital_rst[0] && tx_digital_rst[0] && pll_locked;
    endproperty
    a_ana_rel: assert property (p_ana_rel) else $error("analog release order");

    property p_pwrdn_all;
        $rose(blk_pwrdn) |=> (&tx_digital_rst) && (&rx_analog_rst) && pll_rst;
    endproperty
    a_pwrdn_all: assert property (p_pwrdn_all) else $error("power-down not common");

endmodule : trpc_props

// *** verification/testbench.sv ***
`timescale 1ns/100ps
`include "trpc_map.svh"
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin error_cnt++; \
    $display("mismatch at %0t: got %h expected %h", $time, act, exp); end end

module testbench;
    typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} trpc_exp_t;

    logic        mclk_in   = 1'b0;
    logic        arst_n_in = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        seq_done;
    logic [3:0]  tx_active;
    logic [3:0]  rx_aligned;
    logic [3:0]  bist_ok;
    logic        pwr_on;
    trpc_exp_t   exp_q[$];
    trpc_exp_t   cur_e;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cyc       = 0;
    logic [31:0] lfsr_q    = 32'h00000020;

    initial forever #20 mclk_in = ~mclk_in;

    trpc_if lnk_if ();
    trpc_host #(.RECFG_CYC(3)) trpc_host_inst (
        .mclk_in(mclk_in), .arst_n_in(arst_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .lnk(lnk_if), .seq_done_out(seq_done));
    trpc_dev #(.PLL_LOCK_CYC(8), .CDR_LOCK_CYC(4), .OFFSET_CYC(5)) trpc_dev_inst (
        .mclk_in(mclk_in), .arst_n_in(arst_n_in), .lnk(lnk_if), .tx_active_out(tx_active),
        .rx_aligned_out(rx_aligned), .bist_ok_out(bist_ok), .pwr_on_out(pwr_on));
    // Checker defaults already carry the shortened lock counts
    trpc_props trpc_props_inst (
        .mclk_in(mclk_in), .arst_n_in(arst_n_in), .tx_digital_rst(lnk_if.tx_digital_rst),
        .rx_digital_rst(lnk_if.rx_digital_rst), .rx_analog_rst(lnk_if.rx_analog_rst),
        .pll_rst(lnk_if.pll_rst), .blk_pwrdn(lnk_if.blk_pwrdn), .pll_locked(lnk_if.pll_locked),
        .rx_freq_locked(lnk_if.rx_freq_locked), .recfg_busy(lnk_if.recfg_busy));

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    task automatic complete_run();
        $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    // Expectation is queued before the setup so the monitor never runs dry
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic [31:0] m, input logic ee);
        exp_q.push_back(trpc_exp_t'{ed, m, ee});
        @(posedge mclk_in);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        do @(posedge mclk_in); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_run();
        int n;
        for (n = 0; n < 2000 && seq_done !== 1'b1; n++)
            @(posedge mclk_in);
        `CHK(seq_done, 1'b1)
    endtask : wait_run

    always @(posedge mclk_in)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            cur_e = exp_q.pop_front();
            `CHK(prdata & cur_e.mask, cur_e.data)
            `CHK(pslverr, cur_e.err)
        end
    end

    always @(posedge mclk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    initial
    begin
        int          n;
        int          cnt;
        logic [15:0] hold;
        repeat (3) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        `CHK(lnk_if.tx_digital_rst & lnk_if.rx_digital_rst & lnk_if.rx_analog_rst, 4'hf)
        `CHK(lnk_if.pll_rst, 1'b1)
        `CHK(lnk_if.recfg_busy, 1'b0)
        apb(1'b0, `TRPC_HOLD_OFS, 32'h0, 32'h00000010, 32'h0000ffff, 1'b0);
        apb(1'b0, 12'h00c, 32'h0, 32'h00000000, 32'hffffffff, 1'b1);
        apb(1'b1, 12'h010, 32'h1, 32'h00000000, 32'h00000000, 1'b1);
        apb(1'b0, `TRPC_STATUS_OFS, 32'h0, 32'h00000000, 32'h00000001, 1'b0);
        $display("test reset_values done");
        wait_run();
        apb(1'b0, `TRPC_STATUS_OFS, 32'h0, 32'h00000007, 32'h0000001f, 1'b0);
        for (n = 0; n < 500 && bist_ok !== 4'hf; n++)
            @(posedge mclk_in);
        `CHK(tx_active, 4'hf)
        `CHK(rx_aligned, 4'hf)
        `CHK(bist_ok, 4'hf)
        `CHK(pwr_on, 1'b1)
        $display("test bring_up done");
        // Zero exercises the two-cycle floor, then a random hold
        for (int p = 0; p < 2; p++)
        begin
            lfsr_q = lfsr_next(lfsr_q);
            hold = (p == 0) ? 16'h0000 : (lfsr_q[15:0] & 16'h0007) + 16'h0003;
            apb(1'b1, `TRPC_HOLD_OFS, {16'h0000, hold}, 32'h0, 32'h0, 1'b0);
            apb(1'b0, `TRPC_HOLD_OFS, 32'h0, {16'h0000, hold}, 32'h0000ffff, 1'b0);
            apb(1'b1, `TRPC_CTRL_OFS, 32'h1, 32'h0, 32'h0, 1'b0);
            for (n = 0; n < 50 && lnk_if.rx_digital_rst[0] !== 1'b1; n++)
                @(posedge mclk_in);
            @(posedge mclk_in);
            `CHK(tx_active, 4'h0)
            `CHK(rx_aligned | bist_ok, 4'h0)
            if (hold < 16'h0002)
                hold = 16'h0002;
            cnt = 0;
            for (n = 0; n < 2000 && seq_done !== 1'b1; n++)
            begin
                @(posedge mclk_in);
                if (&lnk_if.rx_freq_locked && lnk_if.rx_digital_rst[0] === 1'b1)
                    cnt++;
            end
            `CHK((cnt >= hold) && (cnt <= hold + 3), 1'b1)
        end
        $display("test hold_count done");
        apb(1'b1, `TRPC_CTRL_OFS, 32'h4, 32'h0, 32'h0, 1'b0);
        // Retune still running: only the reconfig flag may read high
        apb(1'b0, `TRPC_STATUS_OFS, 32'h0, 32'h00000010, 32'h0000001f, 1'b0);
        for (n = 0; n < 50 && lnk_if.pll_rst !== 1'b1; n++)
            @(posedge mclk_in);
        @(posedge mclk_in);
        `CHK(lnk_if.pll_locked, 1'b0)
        `CHK(lnk_if.tx_digital_rst & lnk_if.rx_digital_rst, 4'hf)
        wait_run();
        apb(1'b0, `TRPC_STATUS_OFS, 32'h0, 32'h00000007, 32'h0000001f, 1'b0);
        $display("test reconfig done");
        apb(1'b1, `TRPC_CTRL_OFS, 32'h2, 32'h0, 32'h0, 1'b0);
        repeat (3) @(posedge mclk_in);
        `CHK(lnk_if.blk_pwrdn, 1'b1)
        `CHK(pwr_on, 1'b0)
        `CHK(lnk_if.pll_locked, 1'b0)
        `CHK(lnk_if.rx_freq_locked, 4'h0)
        apb(1'b0, `TRPC_CTRL_OFS, 32'h0, 32'h00000002, 32'h00000007, 1'b0);
        apb(1'b1, `TRPC_CTRL_OFS, 32'h0, 32'h0, 32'h0, 1'b0);
        wait_run();
        `CHK(pwr_on, 1'b1)
        $display("test power_down done");
        // Checked before the next edge, so only an asynchronous clear passes
        @(posedge mclk_in);
        arst_n_in <= 1'b0;
        #1;
        `CHK(lnk_if.pll_rst, 1'b1)
        `CHK(lnk_if.pll_locked, 1'b0)
        `CHK(tx_active, 4'h0)
        @(posedge mclk_in);
        arst_n_in <= 1'b1;
        // Release must wait for a clock edge in the sequencer
        #1;
        `CHK(lnk_if.tx_digital_rst & lnk_if.rx_digital_rst, 4'hf)
        apb(1'b0, `TRPC_STATUS_OFS, 32'h0, 32'h00000008, 32'h0000001f, 1'b0);
        wait_run();
        apb(1'b0, `TRPC_STATUS_OFS, 32'h0, 32'h00000007, 32'h0000001f, 1'b0);
        $display("test async_reset done");
        complete_run();
    end

endmodule : testbench
